// file: common/fei_pkg.sv
// Constants and types for the framing error insertion block
//
// Contract
// - T1 mode, DDS control zero-to-one inverts one 6-bit DDS pattern, then clears.
// - T1 mode, CRC control zero-to-one inverts one 6-bit CRC pattern, then clears.
// - SF or DM format, signalling framing control inverts one Fs bit, then clears.
// - ESF format, signalling framing control inverts one frame alignment bit, then clears.
// - SLC-96 format, signalling framing control inverts one sync Fs bit, then clears.
// - SF, DM, SLC-96, terminal framing control inverts one Ft bit, then clears.
// - E1 mode, CRC control inverts all four CRC bits of one sub-multiframe.
// - E1 mode, CRC multiframe control inverts one 6-bit alignment pattern, then clears.
// - E1 mode, signalling multiframe control inverts one 4-bit pattern, then clears.
// - E1 mode, NFAS control inverts one NFAS bit, then clears.
// - E1 mode, whole FAS control inverts one 7-bit FAS pattern, then clears.
// - E1 mode, single FAS control inverts exactly one FAS bit, then clears.
package fei_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] FEI_INSERT_ADDR = 8'h6f;
    localparam logic [7:0] FEI_COUNT_ADDR  = 8'h70;
    localparam logic [7:0] FEI_STATE_ADDR  = 8'h71;
    localparam logic [7:0] FEI_RESET_VAL   = 8'h00;

    // T1/J1 view of the insert register
    localparam int FEI_T1_FT_BIT  = 0;
    localparam int FEI_T1_FS_BIT  = 1;
    localparam int FEI_T1_CRC_BIT = 2;
    localparam int FEI_T1_DDS_BIT = 3;
    localparam int FEI_T1_NBITS   = 4;

    // E1 view of the insert register
    localparam int FEI_E1_FAS1_BIT   = 0;
    localparam int FEI_E1_FASALL_BIT = 1;
    localparam int FEI_E1_NFAS_BIT   = 2;
    localparam int FEI_E1_CASMF_BIT  = 3;
    localparam int FEI_E1_CRCMF_BIT  = 4;
    localparam int FEI_E1_CRC_BIT    = 5;
    localparam int FEI_E1_NBITS      = 6;

    // Slots: T1 bits at 0..3, E1 bits at 4..9
    localparam int FEI_E1_BASE   = 4;
    localparam int FEI_NUM_SLOTS = 10;
    // Slots whose target is one bit: Ft, Fs, FAS1, NFAS
    localparam logic [9:0] FEI_SINGLE_MASK = 10'h053;

    // ************************************************************
    // Field codes presented by the transmit framer
    // ************************************************************
    typedef logic [3:0] fei_field_t;
    localparam fei_field_t FEI_FLD_NONE     = 4'h0;
    localparam fei_field_t FEI_FLD_DDS      = 4'h1;
    localparam fei_field_t FEI_FLD_CRC6     = 4'h2;
    localparam fei_field_t FEI_FLD_FS       = 4'h3;
    localparam fei_field_t FEI_FLD_FT       = 4'h4;
    localparam fei_field_t FEI_FLD_ESF_FAS  = 4'h5;
    localparam fei_field_t FEI_FLD_SLC_SYNC = 4'h6;
    localparam fei_field_t FEI_FLD_E1_CRC4  = 4'h7;
    localparam fei_field_t FEI_FLD_E1_CRCMF = 4'h8;
    localparam fei_field_t FEI_FLD_E1_CASMF = 4'h9;
    localparam fei_field_t FEI_FLD_E1_NFAS  = 4'ha;
    localparam fei_field_t FEI_FLD_E1_FAS   = 4'hb;

    // T1/J1 frame formats
    typedef logic [1:0] fei_fmt_t;
    localparam fei_fmt_t FEI_FMT_SF  = 2'h0;
    localparam fei_fmt_t FEI_FMT_ESF = 2'h1;
    localparam fei_fmt_t FEI_FMT_DM  = 2'h2;
    localparam fei_fmt_t FEI_FMT_SLC = 2'h3;

    // Per-slot state
    typedef enum logic [2:0] {
        FEI_IDLE   = 3'b001,
        FEI_ARMED  = 3'b010,
        FEI_ACTIVE = 3'b100
    } fei_slot_e;

endpackage

// file: rtl/fei_field_decode.sv
// Maps the framer's current field to the slots that target it
`timescale 1ns/1ps
`default_nettype none
module fei_field_decode
    import fei_pkg::*;
(
    input  wire logic       e1_mode,
    input  wire fei_fmt_t   t1_format,
    input  wire fei_field_t field,
    output logic [9:0]      hit
);

    always_comb begin
        hit = 10'h000;
        if (!e1_mode) begin
            case (field)
                FEI_FLD_DDS:      hit[FEI_T1_DDS_BIT] = 1'b1;
                FEI_FLD_CRC6:     hit[FEI_T1_CRC_BIT] = 1'b1;
                FEI_FLD_FS:       hit[FEI_T1_FS_BIT]  = (t1_format == FEI_FMT_SF) ||
                                                        (t1_format == FEI_FMT_DM);
                FEI_FLD_ESF_FAS:  hit[FEI_T1_FS_BIT]  = (t1_format == FEI_FMT_ESF);
                FEI_FLD_SLC_SYNC: hit[FEI_T1_FS_BIT]  = (t1_format == FEI_FMT_SLC);
                FEI_FLD_FT:       hit[FEI_T1_FT_BIT]  = (t1_format != FEI_FMT_ESF);
                default:          hit = 10'h000;
            endcase
        end else begin
            case (field)
                FEI_FLD_E1_CRC4:  hit[FEI_E1_BASE + FEI_E1_CRC_BIT]   = 1'b1;
                FEI_FLD_E1_CRCMF: hit[FEI_E1_BASE + FEI_E1_CRCMF_BIT] = 1'b1;
                FEI_FLD_E1_CASMF: hit[FEI_E1_BASE + FEI_E1_CASMF_BIT] = 1'b1;
                FEI_FLD_E1_NFAS:  hit[FEI_E1_BASE + FEI_E1_NFAS_BIT]  = 1'b1;
                FEI_FLD_E1_FAS: begin
                    hit[FEI_E1_BASE + FEI_E1_FASALL_BIT] = 1'b1;
                    hit[FEI_E1_BASE + FEI_E1_FAS1_BIT]   = 1'b1;
                end
                default:          hit = 10'h000;
            endcase
        end
    end

endmodule
`default_nettype wire

// file: rtl/fei_inject_slot.sv
// One self-clearing inversion request and its tracking state
`timescale 1ns/1ps
`default_nettype none
module fei_inject_slot
    import fei_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic arm,
    input  wire logic abort,
    input  wire logic valid,
    input  wire logic hit,
    input  wire logic first,
    input  wire logic last,
    input  wire logic single,
    output logic      invert,
    output logic      busy,
    output logic      active,
    output logic      done
);

    fei_slot_e state_q;
    fei_slot_e state_d;

    always_comb begin
        state_d = state_q;
        invert  = 1'b0;
        done    = 1'b0;
        case (state_q)
            FEI_IDLE: begin
                if (arm) begin
                    state_d = FEI_ARMED;
                end
            end
            // Wait for an occurrence start so that only an abort can leave a pattern half inverted
            FEI_ARMED: begin
                if (valid && hit && first) begin
                    invert = 1'b1;
                    if (single || last) begin
                        state_d = FEI_IDLE;
                        done    = 1'b1;
                    end else begin
                        state_d = FEI_ACTIVE;
                    end
                end
            end
            FEI_ACTIVE: begin
                if (valid && hit) begin
                    invert = 1'b1;
                    if (last) begin
                        state_d = FEI_IDLE;
                        done    = 1'b1;
                    end
                end
            end
            default: state_d = FEI_IDLE;
        endcase
        // A write in the changing cycle already targets the new mode
        if (abort) begin
            state_d = arm ? FEI_ARMED : FEI_IDLE;
            invert  = 1'b0;
            done    = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= FEI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign busy   = (state_q != FEI_IDLE);
    assign active = (state_q == FEI_ACTIVE);

endmodule
`default_nettype wire

// file: rtl/fei_top.sv
// Transmit framing error insertion: register port and bit stream inverter
`timescale 1ns/1ps
`default_nettype none
module fei_top
    import fei_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    input  wire logic       e1_mode,
    input  wire fei_fmt_t   t1_format,
    input  wire logic       tx_bit,
    input  wire logic       tx_valid,
    input  wire fei_field_t tx_field,
    input  wire logic       tx_first,
    input  wire logic       tx_last,
    output logic            tx_bit_out,
    output logic            tx_valid_out,
    output logic            tx_first_out,
    output logic            tx_last_out,
    output fei_field_t      tx_field_out,
    output logic            inject_busy
);

    // ************************************************************
    // Signals
    // ************************************************************
    logic [FEI_NUM_SLOTS-1:0] hit;
    logic [FEI_NUM_SLOTS-1:0] arm;
    logic [FEI_NUM_SLOTS-1:0] slot_inv;
    logic [FEI_NUM_SLOTS-1:0] slot_busy;
    logic [FEI_NUM_SLOTS-1:0] slot_active;
    logic [FEI_NUM_SLOTS-1:0] slot_done;
    logic                     wr_insert;
    logic                     wr_count;
    logic                     abort;
    logic                     e1_mode_q;
    fei_fmt_t                 t1_format_q;
    logic [7:0]               count_q;
    logic [7:0]               insert_view;
    logic [7:0]               state_view;
    logic [7:0]               rdata_d;
    logic                     any_done;

    assign wr_insert = reg_wr && (reg_addr == FEI_INSERT_ADDR);
    assign wr_count  = reg_wr && (reg_addr == FEI_COUNT_ADDR);

    // ************************************************************
    // Mode tracking
    // ************************************************************
    // A mode or format change can retarget any slot, so every pending request is dropped
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            e1_mode_q   <= 1'b0;
            t1_format_q <= FEI_FMT_SF;
        end else begin
            e1_mode_q   <= e1_mode;
            t1_format_q <= t1_format;
        end
    end

    assign abort = (e1_mode != e1_mode_q) || (t1_format != t1_format_q);

    // ************************************************************
    // Arming from register writes
    // ************************************************************
    // Only a zero-to-one change arms a slot; ones held and zeros are ignored
    always_comb begin
        arm = '0;
        for (int i = 0; i < FEI_T1_NBITS; i++) begin
            arm[i] = wr_insert && !e1_mode && reg_wdata[i] && (!slot_busy[i] || abort);
        end
        for (int i = 0; i < FEI_E1_NBITS; i++) begin
            arm[FEI_E1_BASE + i] = wr_insert && e1_mode && reg_wdata[i] &&
                                   (!slot_busy[FEI_E1_BASE + i] || abort);
        end
    end

    // ************************************************************
    // Field decode and request slots
    // ************************************************************
    fei_field_decode u_decode (
        .e1_mode   (e1_mode),
        .t1_format (t1_format),
        .field     (tx_field),
        .hit       (hit)
    );

    generate
        for (genvar g = 0; g < FEI_NUM_SLOTS; g++) begin : g_slot
            fei_inject_slot u_slot (
                .mclk   (mclk),
                .resetn (resetn),
                .arm    (arm[g]),
                .abort  (abort),
                .valid  (tx_valid),
                .hit    (hit[g]),
                .first  (tx_first),
                .last   (tx_last),
                .single (FEI_SINGLE_MASK[g]),
                .invert (slot_inv[g]),
                .busy   (slot_busy[g]),
                .active (slot_active[g]),
                .done   (slot_done[g])
            );
        end
    endgenerate

    // ************************************************************
    // Transmit stream
    // ************************************************************
    // One cycle of latency; every field marker is delayed with the data
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_bit_out   <= 1'b0;
            tx_valid_out <= 1'b0;
            tx_first_out <= 1'b0;
            tx_last_out  <= 1'b0;
            tx_field_out <= FEI_FLD_NONE;
        end else begin
            tx_bit_out   <= tx_bit ^ (|slot_inv);
            tx_valid_out <= tx_valid;
            tx_first_out <= tx_first;
            tx_last_out  <= tx_last;
            tx_field_out <= tx_field;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            inject_busy <= 1'b0;
        end else begin
            inject_busy <= |(slot_busy & ~slot_done);
        end
    end

    // ************************************************************
    // Completed inversion counter
    // ************************************************************
    // Completion in the clearing cycle still counts
    assign any_done = |slot_done;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= FEI_RESET_VAL;
        end else if (wr_count) begin
            count_q <= any_done ? 8'h01 : 8'h00;
        end else if (any_done && (count_q != 8'hff)) begin
            count_q <= count_q + 8'h01;
        end
    end

    // ************************************************************
    // Register read
    // ************************************************************
    // Control bits read one until their inversion completes (self clear)
    always_comb begin
        insert_view = 8'h00;
        state_view  = 8'h00;
        if (e1_mode) begin
            insert_view[FEI_E1_NBITS-1:0] = slot_busy[FEI_NUM_SLOTS-1:FEI_E1_BASE];
            state_view[FEI_E1_NBITS-1:0]  = slot_active[FEI_NUM_SLOTS-1:FEI_E1_BASE];
        end else begin
            insert_view[FEI_T1_NBITS-1:0] = slot_busy[FEI_T1_NBITS-1:0];
            state_view[FEI_T1_NBITS-1:0]  = slot_active[FEI_T1_NBITS-1:0];
        end
    end

    always_comb begin
        case (reg_addr)
            FEI_INSERT_ADDR: rdata_d = insert_view;
            FEI_COUNT_ADDR:  rdata_d = count_q;
            FEI_STATE_ADDR:  rdata_d = state_view;
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// file: verification/fei_top_asserts.sv
// Port-level checker for the framing error insertion block
`timescale 1ns/1ps
`default_nettype none
module fei_top_asserts
    import fei_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       e1_mode,
    input wire fei_fmt_t   t1_format,
    input wire logic       tx_bit,
    input wire logic       tx_valid,
    input wire fei_field_t tx_field,
    input wire logic       tx_first,
    input wire logic       tx_last,
    input wire logic       tx_bit_out,
    input wire logic       tx_valid_out,
    input wire logic       tx_first_out,
    input wire logic       tx_last_out,
    input wire fei_field_t tx_field_out,
    input wire logic       inject_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_side_copy:
        assert property (1 |=> tx_valid_out == $past(tx_valid) && tx_field_out == $past(tx_field)
            && tx_first_out == $past(tx_first) && tx_last_out == $past(tx_last))
        else $error("side band copy wrong");
    a_invalid_kept:
        assert property (!tx_valid |=> tx_bit_out == $past(tx_bit))
        else $error("invalid bit altered");
    a_none_kept:
        assert property (tx_field == FEI_FLD_NONE |=> tx_bit_out == $past(tx_bit))
        else $error("payload bit altered");
    a_idle_kept:
        assert property (!inject_busy && !$past(reg_wr) |=> tx_bit_out == $past(tx_bit))
        else $error("bit altered with nothing pending");
    a_rdata_idle:
        assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero:
        assert property (reg_rd && (reg_addr < FEI_INSERT_ADDR || reg_addr > FEI_STATE_ADDR)
            |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_t1_view:
        assert property (reg_rd && reg_addr == FEI_INSERT_ADDR && !e1_mode
            |=> reg_rdata[7:4] == 4'h0)
        else $error("T1 view upper bits set");
    a_e1_view:
        assert property (reg_rd && reg_addr == FEI_INSERT_ADDR && e1_mode
            |=> reg_rdata[7:6] == 2'h0)
        else $error("E1 view upper bits set");
    a_arm_busy:
        assert property (reg_wr && reg_addr == FEI_INSERT_ADDR && $stable(e1_mode)
            && $stable(t1_format) && (e1_mode ? |reg_wdata[5:0] : |reg_wdata[3:0])
            |=> ##1 (inject_busy || tx_valid_out))
        else $error("request not pending after write");
endmodule

bind fei_top fei_top_asserts u_fei_chk (
    .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .e1_mode,
    .t1_format, .tx_bit, .tx_valid, .tx_field, .tx_first, .tx_last, .tx_bit_out,
    .tx_valid_out, .tx_first_out, .tx_last_out, .tx_field_out, .inject_busy
);
`default_nettype wire

// file: verification/tb_fei_top.sv
// Self-checking testbench for the framing error insertion block
`timescale 1ns/1ps
`default_nettype none
module tb_fei_top
    import fei_pkg::*;
;
    typedef struct {
        logic       e1;
        fei_fmt_t   fmt;
        logic [7:0] wd;
        fei_field_t fld;
        int         n;
        int         inv;
    } fei_row_s;

    fei_row_s   rows [15] = '{
        '{1'b0, FEI_FMT_SF, 8'h08, FEI_FLD_DDS, 6, 6},
        '{1'b0, FEI_FMT_ESF, 8'h04, FEI_FLD_CRC6, 6, 6},
        '{1'b0, FEI_FMT_SF, 8'h02, FEI_FLD_FS, 1, 1},
        '{1'b0, FEI_FMT_DM, 8'h02, FEI_FLD_FS, 1, 1},
        '{1'b0, FEI_FMT_ESF, 8'h02, FEI_FLD_ESF_FAS, 1, 1},
        '{1'b0, FEI_FMT_SLC, 8'h02, FEI_FLD_SLC_SYNC, 1, 1},
        '{1'b0, FEI_FMT_SF, 8'h01, FEI_FLD_FT, 1, 1},
        '{1'b0, FEI_FMT_DM, 8'h01, FEI_FLD_FT, 1, 1},
        '{1'b0, FEI_FMT_SLC, 8'h01, FEI_FLD_FT, 1, 1},
        '{1'b1, FEI_FMT_SF, 8'h20, FEI_FLD_E1_CRC4, 4, 4},
        '{1'b1, FEI_FMT_SF, 8'h10, FEI_FLD_E1_CRCMF, 6, 6},
        '{1'b1, FEI_FMT_SF, 8'h08, FEI_FLD_E1_CASMF, 4, 4},
        '{1'b1, FEI_FMT_SF, 8'h04, FEI_FLD_E1_NFAS, 1, 1},
        '{1'b1, FEI_FMT_SF, 8'h02, FEI_FLD_E1_FAS, 7, 7},
        '{1'b1, FEI_FMT_SF, 8'h01, FEI_FLD_E1_FAS, 7, 1}
    };
    logic       mclk, resetn, reg_wr, reg_rd, e1_mode, tx_bit, tx_valid, tx_first, tx_last;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       tx_bit_out, inject_busy;
    fei_fmt_t   t1_format;
    fei_field_t tx_field;
    int         bad_count = 0;
    int         compares = 0;

    fei_top dut (
        .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e1_mode(e1_mode),
        .t1_format(t1_format), .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_field(tx_field),
        .tx_first(tx_first), .tx_last(tx_last), .tx_bit_out(tx_bit_out),
        .tx_valid_out(), .tx_first_out(), .tx_last_out(), .tx_field_out(),
        .inject_busy(inject_busy)
    );

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // One pattern occurrence; the first inv bits must come out inverted
    task automatic send(input fei_field_t f, input int n, input int inv, input logic v);
        for (int i = 0; i <= n; i++) begin
            @(posedge mclk);
            tx_valid <= v && i < n;
            tx_field <= (i < n) ? f : FEI_FLD_NONE;
            tx_bit   <= i[0];
            tx_first <= i == 0;
            tx_last  <= i == n - 1;
            #1;
            if (i > 0) begin
                chk({7'h00, tx_bit_out}, {7'h00, ~i[0] ^ (i <= inv)});
            end
        end
    endtask

    // Mode change drops pending work, so let it settle first
    task automatic set_mode(input logic e, input fei_fmt_t f);
        @(posedge mclk);
        e1_mode   <= e;
        t1_format <= f;
        repeat (2) @(posedge mclk);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        {reg_wr, reg_rd, e1_mode, tx_bit, tx_valid, tx_first, tx_last} = 7'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        t1_format = FEI_FMT_SF;
        tx_field = FEI_FLD_NONE;
        resetn = 1'b0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        foreach (rows[k]) begin
            set_mode(rows[k].e1, rows[k].fmt);
            wr(FEI_COUNT_ADDR, 8'h00);
            wr(FEI_INSERT_ADDR, rows[k].wd);
            rd(FEI_INSERT_ADDR, rows[k].wd);
            send(rows[k].fld, rows[k].n, 0, 1'b0);
            send(rows[k].fld, rows[k].n, rows[k].inv, 1'b1);
            send(rows[k].fld, rows[k].n, 0, 1'b1);
            rd(FEI_INSERT_ADDR, 8'h00);
            rd(FEI_COUNT_ADDR, 8'h01);
        end
        // ************************************************************
        // Awkward cases
        // ************************************************************
        // A write landing mid-pattern waits for the next occurrence
        @(posedge mclk);
        tx_valid  <= 1'b1;
        tx_field  <= FEI_FLD_E1_FAS;
        tx_first  <= 1'b1;
        tx_last   <= 1'b0;
        tx_bit    <= 1'b0;
        @(posedge mclk);
        tx_first  <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= FEI_INSERT_ADDR;
        reg_wdata <= 8'h02;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        tx_last   <= 1'b1;
        #1;
        chk({7'h00, tx_bit_out}, 8'h00);
        @(posedge mclk);
        tx_valid  <= 1'b0;
        tx_last   <= 1'b0;
        tx_field  <= FEI_FLD_NONE;
        #1;
        chk({7'h00, tx_bit_out}, 8'h00);
        @(posedge mclk);
        #1;
        chk({7'h00, tx_bit_out}, 8'h00);
        rd(FEI_INSERT_ADDR, 8'h02);
        send(FEI_FLD_E1_FAS, 7, 7, 1'b1);
        rd(FEI_INSERT_ADDR, 8'h00);
        // In-progress view while a pattern is paused mid-way
        wr(FEI_INSERT_ADDR, 8'h02);
        @(posedge mclk);
        tx_valid  <= 1'b1;
        tx_field  <= FEI_FLD_E1_FAS;
        tx_first  <= 1'b1;
        @(posedge mclk);
        tx_valid  <= 1'b0;
        tx_first  <= 1'b0;
        rd(FEI_STATE_ADDR, 8'h02);
        chk({7'h00, inject_busy}, 8'h01);
        @(posedge mclk);
        tx_field  <= FEI_FLD_NONE;
        set_mode(1'b0, FEI_FMT_SF);
        wr(FEI_INSERT_ADDR, 8'h01);
        wr(FEI_INSERT_ADDR, 8'h00);
        rd(FEI_INSERT_ADDR, 8'h01);
        wr(FEI_INSERT_ADDR, 8'h01);
        send(FEI_FLD_FT, 1, 1, 1'b1);
        send(FEI_FLD_FT, 1, 0, 1'b1);
        set_mode(1'b0, FEI_FMT_ESF);
        wr(FEI_INSERT_ADDR, 8'h01);
        send(FEI_FLD_FT, 1, 0, 1'b1);
        rd(FEI_INSERT_ADDR, 8'h01);
        set_mode(1'b0, FEI_FMT_SF);
        rd(FEI_INSERT_ADDR, 8'h00);
        rd(8'h6e, 8'h00);
        wr(8'h72, 8'hff);
        rd(8'h72, 8'h00);
        rd(FEI_INSERT_ADDR, 8'h00);
        // Count saturates rather than wrapping
        wr(FEI_COUNT_ADDR, 8'h00);
        repeat (256) begin
            wr(FEI_INSERT_ADDR, 8'h01);
            send(FEI_FLD_FT, 1, 1, 1'b1);
        end
        rd(FEI_COUNT_ADDR, 8'hff);
        wr(FEI_INSERT_ADDR, 8'h01);
        @(posedge mclk);
        resetn <= 1'b0;
        @(posedge mclk);
        #1;
        chk({7'h00, inject_busy}, 8'h00);
        @(posedge mclk);
        resetn <= 1'b1;
        rd(FEI_INSERT_ADDR, 8'h00);
        rd(FEI_COUNT_ADDR, 8'h00);
        rd(FEI_STATE_ADDR, 8'h00);
        tally_and_finish();
    end

    // Whole run needs about 1500 cycles
    initial begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
